// File: logic/io_space_map.vh
// Address map, field layout and op codes of the lower I/O register space
`ifndef IO_SPACE_MAP_VH
`define IO_SPACE_MAP_VH
`define IO_WIN_LAST       8'h3f
`define IO_BIT_LAST       8'h1f
`define IO_DATA_OFFSET    8'h20
`define IO_EXT_FIRST      8'h60
`define IO_EXT_LAST       8'hff
`define A_PORT_B_OUTPUT_LATCH_IN        6'h03
`define A_PORT_B_OUTPUT_LATCH_DIR       6'h04
`define A_PORT_B_OUTPUT_LATCH_OUT       6'h05
`define A_PORT_C_OUTPUT_LATCH_IN        6'h06
`define A_PORT_C_OUTPUT_LATCH_DIR       6'h07
`define A_PORT_C_OUTPUT_LATCH_OUT       6'h08
`define A_PORT_D_OUTPUT_LATCH_IN        6'h09
`define A_PORT_D_OUTPUT_LATCH_DIR       6'h0a
`define A_PORT_D_OUTPUT_LATCH_OUT       6'h0b
`define A_TMR0_FLAGS      6'h15
`define A_TMR1_FLAGS      6'h16
`define A_TMR2_FLAGS      6'h17
`define A_PCHG_FLAGS      6'h1b
`define A_EXT_FLAGS       6'h1c
`define A_EXT_MASK        6'h1d
`define A_SCRATCH0        6'h1e
`define A_NV_CTRL         6'h1f
`define A_NV_DATA         6'h20
`define A_NV_ADDR_LO      6'h21
`define A_NV_ADDR_HI      6'h22
`define A_PRESC_SYNC      6'h23
`define A_TMR0_CTRL_A     6'h24
`define A_TMR0_CTRL_B     6'h25
`define A_TMR0_COUNT      6'h26
`define A_TMR0_CMP_A      6'h27
`define A_TMR0_CMP_B      6'h28
`define A_SCRATCH1        6'h2a
`define A_SCRATCH2        6'h2b
`define A_SER_CTRL        6'h2c
`define A_SER_STATE       6'h2d
`define A_SER_DATA        6'h2e
`define A_CMP_CTRL        6'h30
`define A_SLEEP_CTRL      6'h33
`define A_RESET_CAUSE     6'h34
// Per-register bit masks: writable, write-one-to-clear and read-only bits
`define M_PORT_C_OUTPUT_LATCH           8'h7f
`define M_TMR0_FLAGS      8'h07
`define M_TMR1_FLAGS      8'h27
`define M_TMR2_FLAGS      8'h07
`define M_PCHG_FLAGS      8'h07
`define M_EXT_FLAGS       8'h03
`define M_NV_CTRL         8'h3f
`define M_TMR0_CTRL_A     8'hf3
`define M_TMR0_CTRL_B     8'hcf
`define M_PRESC_SYNC      8'h83
`define M_SER_STATE_RW    8'h01
`define M_SER_STATE_W1C   8'hc0
`define M_CMP_RW          8'hdf
`define M_CMP_W1C         8'h10
`define M_CMP_RO          8'h20
`define M_SLEEP_CTRL      8'h0f
`define M_RESET_CAUSE     8'h0f
`define RESET_VALUE       8'h00
// Access kinds issued by the core
`define OP_NONE           4'h0
`define OP_IO_READ        4'h1
`define OP_IO_WRITE       4'h2
`define OP_BIT_SET        4'h3
`define OP_BIT_CLEAR      4'h4
`define OP_SKIP_HIGH      4'h5
`define OP_SKIP_LOW       4'h6
`define OP_MEM_FETCH      4'h7
`define OP_MEM_WRITE      4'h8
`endif

// File: logic/io_addr_decode.v
// Maps core accesses onto a 6-bit I/O register index
`timescale 1ns/100ps
`include "io_space_map.vh"
module io_addr_decode (
    // Access from core
    input  wire [3:0] op,
    input  wire [7:0] ioAddr,
    input  wire [7:0] dataAddr,
    // Decoded target
    output reg  [5:0] regIndex,
    output reg        inWindow,
    output reg        bitOp,
    output reg        extHit
);
    // Full-width mirror subtraction, cut to the 6-bit index below
    reg  [7:0] mirrorAddr;

    // Address path depends on instruction class
    always @* begin
        mirrorAddr = dataAddr - `IO_DATA_OFFSET;
        regIndex = 6'h00;
        inWindow = 1'b0;
        bitOp    = 1'b0;
        extHit   = 1'b0;
        case (op)
            `OP_IO_READ, `OP_IO_WRITE: begin
                regIndex = ioAddr[5:0];
                inWindow = (ioAddr <= `IO_WIN_LAST);
            end
            `OP_BIT_SET, `OP_BIT_CLEAR, `OP_SKIP_HIGH, `OP_SKIP_LOW: begin
                regIndex = ioAddr[5:0];
                inWindow = (ioAddr <= `IO_BIT_LAST);
                bitOp    = inWindow;
            end
            `OP_MEM_FETCH, `OP_MEM_WRITE: begin
                // Data address minus the mirror offset
                regIndex = mirrorAddr[5:0];
                inWindow = (dataAddr >= `IO_DATA_OFFSET)
                           && (dataAddr < `IO_EXT_FIRST);
                extHit   = (dataAddr >= `IO_EXT_FIRST);
            end
            default: begin
                regIndex = 6'h00;
            end
        endcase
    end
endmodule // io_addr_decode

// File: logic/io_bit_select.v
// One-hot bit mask and selected-bit test for single-bit ops
`timescale 1ns/100ps
`include "io_space_map.vh"
module io_bit_select (
    // Operand
    input  wire [2:0] bitNum,
    input  wire [7:0] regValue,
    // Results
    output wire [7:0] bitMask,
    output wire       bitValue
);
    // Shift a single one into place
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : gMask
            assign bitMask[i] = (bitNum == i[2:0]);
        end
    endgenerate
    assign bitValue = |(regValue & bitMask);
endmodule // io_bit_select

// File: logic/io_register_space_decode.v
// Lower I/O register space: decode, storage, bit access and flag clearing
// What this block does
// - Locations 0x00-0x1F take single-bit set and clear, higher ones do not.
// - Locations 0x00-0x1F let skip ops test one chosen bit.
// - Some status flags clear on a written one and ignore a written zero.
// - Single-bit set or clear changes only the addressed bit, never other flags.
// - I/O read and write decode a 6-bit address 0x00-0x3F.
// - Each I/O register also sits in data space at its address plus 0x20.
// - Extended space 0x60-0xFF is reached only through data-space load/store.
`timescale 1ns/100ps
`include "io_space_map.vh"
module io_register_space_decode (
    // Clock and reset
    input  wire       clock,
    input  wire       rst,
    // Core access
    input  wire [3:0] op,
    input  wire [7:0] ioAddr,
    input  wire [7:0] dataAddr,
    input  wire [2:0] bitNum,
    input  wire [7:0] writeData,
    output reg  [7:0] readData,
    output reg        skipTaken,
    output wire       extSelect,
    // Port pins
    input  wire [7:0] portBPins,
    input  wire [6:0] portCPins,
    input  wire [7:0] portDPins,
    output wire [7:0] portBDir,
    output wire [7:0] portBOut,
    output wire [6:0] portCDir,
    output wire [6:0] portCOut,
    output wire [7:0] portDDir,
    output wire [7:0] portDOut,
    // Peripheral flag set pulses
    input  wire [7:0] tmr0FlagSet,
    input  wire [7:0] tmr1FlagSet,
    input  wire [7:0] tmr2FlagSet,
    input  wire [7:0] pchgFlagSet,
    input  wire [7:0] extFlagSet,
    input  wire [7:0] serFlagSet,
    input  wire [7:0] cmpFlagSet,
    input  wire [7:0] resetCauseSet,
    input  wire       cmpOutput,
    // Register contents towards peripherals
    output wire [7:0] extIrqMask,
    output wire [7:0] timer0Count,
    output wire [7:0] serialData,
    output wire [7:0] nvControl
);
    wire [5:0] regIndex;
    wire       inWindow;
    wire       bitOp;
    wire       extHit;
    wire [7:0] bitMask;
    wire       bitValue;
    reg  [7:0] curValue;
    reg        wrEn;
    reg  [7:0] w1cMask;

    // Pin synchronisers, two stages before any reader
    reg  [22:0] pinMeta_q;
    reg  [22:0] pinSync_q;

    // Storage, one byte per 64 locations; reserved ones never written
    reg  [7:0] regs_q [0:63];

    io_addr_decode uDecode (
        .op       (op),
        .ioAddr   (ioAddr),
        .dataAddr (dataAddr),
        .regIndex (regIndex),
        .inWindow (inWindow),
        .bitOp    (bitOp),
        .extHit   (extHit)
    );

    io_bit_select uBitSel (
        .bitNum   (bitNum),
        .regValue (curValue),
        .bitMask  (bitMask),
        .bitValue (bitValue)
    );

    // Extended space goes out to its owner only on load/store
    assign extSelect = extHit;

    // Synchronise pins
    always @(posedge clock) begin
        if (rst) begin
            pinMeta_q <= 23'h000000;
            pinSync_q <= 23'h000000;
        end else begin
            pinMeta_q <= {portDPins, portCPins, portBPins};
            pinSync_q <= pinMeta_q;
        end
    end

    // Current value of the addressed location; unmapped reads zero
    always @* begin
        case (regIndex)
            `A_PORT_B_OUTPUT_LATCH_IN:    curValue = pinSync_q[7:0];
            `A_PORT_C_OUTPUT_LATCH_IN:    curValue = {1'b0, pinSync_q[14:8]};
            `A_PORT_D_OUTPUT_LATCH_IN:    curValue = pinSync_q[22:15];
            `A_PORT_B_OUTPUT_LATCH_DIR, `A_PORT_B_OUTPUT_LATCH_OUT, `A_PORT_D_OUTPUT_LATCH_DIR, `A_PORT_D_OUTPUT_LATCH_OUT,
            `A_EXT_MASK, `A_SCRATCH0, `A_NV_DATA, `A_NV_ADDR_LO,
            `A_NV_ADDR_HI, `A_TMR0_COUNT, `A_TMR0_CMP_A, `A_TMR0_CMP_B,
            `A_SCRATCH1, `A_SCRATCH2, `A_SER_CTRL, `A_SER_DATA,
            `A_PORT_C_OUTPUT_LATCH_DIR, `A_PORT_C_OUTPUT_LATCH_OUT, `A_TMR0_FLAGS, `A_TMR1_FLAGS,
            `A_TMR2_FLAGS, `A_PCHG_FLAGS, `A_EXT_FLAGS, `A_NV_CTRL,
            `A_PRESC_SYNC, `A_TMR0_CTRL_A, `A_SER_STATE, `A_SLEEP_CTRL,
            `A_RESET_CAUSE:
                curValue = regs_q[regIndex];
            `A_TMR0_CTRL_B: curValue = regs_q[regIndex] & 8'h0f; // Force bits read zero
            `A_CMP_CTRL:    curValue = (regs_q[regIndex] & `M_CMP_RW)
                                       | (cmpOutput ? `M_CMP_RO : 8'h00);
            default:        curValue = `RESET_VALUE;
        endcase
    end

    // Writable and write-one-to-clear masks for the addressed location
    always @* begin
        wrEn    = 1'b0;
        w1cMask = 8'h00;
        case (regIndex)
            `A_PORT_B_OUTPUT_LATCH_DIR, `A_PORT_B_OUTPUT_LATCH_OUT, `A_PORT_D_OUTPUT_LATCH_DIR, `A_PORT_D_OUTPUT_LATCH_OUT,
            `A_EXT_MASK, `A_SCRATCH0, `A_NV_DATA, `A_NV_ADDR_LO,
            `A_NV_ADDR_HI, `A_TMR0_COUNT, `A_TMR0_CMP_A, `A_TMR0_CMP_B,
            `A_SCRATCH1, `A_SCRATCH2, `A_SER_CTRL, `A_SER_DATA:
                wrEn = 1'b1;
            `A_PORT_C_OUTPUT_LATCH_DIR, `A_PORT_C_OUTPUT_LATCH_OUT, `A_NV_CTRL, `A_PRESC_SYNC,
            `A_TMR0_CTRL_A, `A_TMR0_CTRL_B, `A_SLEEP_CTRL, `A_SER_STATE,
            `A_CMP_CTRL:
                wrEn = 1'b1;
            `A_TMR0_FLAGS:  w1cMask = `M_TMR0_FLAGS;
            `A_TMR1_FLAGS:  w1cMask = `M_TMR1_FLAGS;
            `A_TMR2_FLAGS:  w1cMask = `M_TMR2_FLAGS;
            `A_PCHG_FLAGS:  w1cMask = `M_PCHG_FLAGS;
            `A_EXT_FLAGS:   w1cMask = `M_EXT_FLAGS;
            `A_RESET_CAUSE: w1cMask = 8'h00; // Cleared by writing zero
            default:        wrEn = 1'b0;
        endcase
        if (regIndex == `A_SER_STATE)
            w1cMask = `M_SER_STATE_W1C;
        if (regIndex == `A_CMP_CTRL)
            w1cMask = `M_CMP_W1C;
    end

    // Per-location writable mask, reserved bits stay zero
    function [7:0] rwMask;
        input [5:0] idx;
        begin
            case (idx)
                `A_PORT_C_OUTPUT_LATCH_DIR, `A_PORT_C_OUTPUT_LATCH_OUT: rwMask = `M_PORT_C_OUTPUT_LATCH;
                `A_NV_CTRL:       rwMask = `M_NV_CTRL;
                `A_PRESC_SYNC:    rwMask = `M_PRESC_SYNC;
                `A_TMR0_CTRL_A:   rwMask = `M_TMR0_CTRL_A;
                `A_TMR0_CTRL_B:   rwMask = `M_TMR0_CTRL_B;
                `A_SLEEP_CTRL:    rwMask = `M_SLEEP_CTRL;
                `A_SER_STATE:     rwMask = `M_SER_STATE_RW;
                `A_CMP_CTRL:      rwMask = `M_CMP_RW & ~`M_CMP_W1C;
                `A_TMR0_FLAGS, `A_TMR1_FLAGS, `A_TMR2_FLAGS, `A_PCHG_FLAGS,
                `A_EXT_FLAGS, `A_RESET_CAUSE:
                                  rwMask = 8'h00;
                default:          rwMask = 8'hff;
            endcase
        end
    endfunction

    // Hardware flag sources per location; pulses come in as arguments so
    // that the caller re-evaluates on every pulse, not only once at start
    function [7:0] flagSrc;
        input [5:0] idx;
        input [7:0] t0Set;
        input [7:0] t1Set;
        input [7:0] t2Set;
        input [7:0] pcSet;
        input [7:0] exSet;
        input [7:0] srSet;
        input [7:0] cmSet;
        input [7:0] rcSet;
        begin
            case (idx)
                `A_TMR0_FLAGS:  flagSrc = t0Set & `M_TMR0_FLAGS;
                `A_TMR1_FLAGS:  flagSrc = t1Set & `M_TMR1_FLAGS;
                `A_TMR2_FLAGS:  flagSrc = t2Set & `M_TMR2_FLAGS;
                `A_PCHG_FLAGS:  flagSrc = pcSet & `M_PCHG_FLAGS;
                `A_EXT_FLAGS:   flagSrc = exSet & `M_EXT_FLAGS;
                `A_SER_STATE:   flagSrc = srSet & `M_SER_STATE_W1C;
                `A_CMP_CTRL:    flagSrc = cmSet & `M_CMP_W1C;
                `A_RESET_CAUSE: flagSrc = rcSet & `M_RESET_CAUSE;
                default:        flagSrc = 8'h00;
            endcase
        end
    endfunction

    // Whole-byte write image vs single-bit image
    wire isWrite  = inWindow && (op == `OP_IO_WRITE || op == `OP_MEM_WRITE);
    wire isBitSet = bitOp && (op == `OP_BIT_SET);
    wire isBitClr = bitOp && (op == `OP_BIT_CLEAR);

    // Register update; one location per cycle, flags set by hardware win
    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1) begin : gReg
            wire       hit = (regIndex == g[5:0]) && (isWrite || isBitSet || isBitClr);
            wire [7:0] rw  = rwMask(g[5:0]);
            wire [7:0] set = flagSrc(g[5:0], tmr0FlagSet, tmr1FlagSet, tmr2FlagSet,
                                     pchgFlagSet, extFlagSet, serFlagSet, cmpFlagSet,
                                     resetCauseSet);
            reg  [7:0] nxt_d;
            always @* begin
                nxt_d = regs_q[g];
                if (hit && (wrEn || w1cMask != 8'h00 || g == `A_RESET_CAUSE)) begin
                    if (isWrite) begin
                        // Byte write: plain bits take data, one clears a flag
                        nxt_d = (regs_q[g] & ~rw) | (writeData & rw);
                        nxt_d = nxt_d & ~(writeData & w1cMask);
                        if (g == `A_RESET_CAUSE)
                            nxt_d = regs_q[g] & writeData & `M_RESET_CAUSE;
                    end else if (isBitSet) begin
                        // Only the addressed bit moves, other flags untouched
                        nxt_d = regs_q[g] | (bitMask & rw);
                        nxt_d = nxt_d & ~(bitMask & w1cMask);
                    end else begin
                        // A zero landing on a flag keeps it pending
                        nxt_d = regs_q[g] & ~(bitMask & rw);
                    end
                end
                nxt_d = nxt_d | set; // Set wins over clear
            end
            always @(posedge clock) begin
                if (rst)
                    regs_q[g] <= `RESET_VALUE;
                else
                    regs_q[g] <= nxt_d;
            end
        end
    endgenerate

    // Registered read answer and skip test, one cycle after the access
    always @(posedge clock) begin
        if (rst) begin
            readData  <= 8'h00;
            skipTaken <= 1'b0;
        end else begin
            readData  <= (inWindow && (op == `OP_IO_READ || op == `OP_MEM_FETCH))
                         ? curValue : 8'h00;
            skipTaken <= bitOp && ((op == `OP_SKIP_HIGH && bitValue)
                         || (op == `OP_SKIP_LOW && !bitValue));
        end
    end

    // Register contents to pins and peripherals
    assign portBDir    = regs_q[`A_PORT_B_OUTPUT_LATCH_DIR];
    assign portBOut    = regs_q[`A_PORT_B_OUTPUT_LATCH_OUT];
    assign portCDir    = regs_q[`A_PORT_C_OUTPUT_LATCH_DIR][6:0];
    assign portCOut    = regs_q[`A_PORT_C_OUTPUT_LATCH_OUT][6:0];
    assign portDDir    = regs_q[`A_PORT_D_OUTPUT_LATCH_DIR];
    assign portDOut    = regs_q[`A_PORT_D_OUTPUT_LATCH_OUT];
    assign extIrqMask  = regs_q[`A_EXT_MASK];
    assign timer0Count = regs_q[`A_TMR0_COUNT];
    assign serialData  = regs_q[`A_SER_DATA];
    assign nvControl   = regs_q[`A_NV_CTRL];
endmodule // io_register_space_decode

// File: testbench/io_space_asserts.sv
// Concurrent checks on the lower I/O register space ports
`timescale 1ns/100ps
`include "io_space_map.vh"
module io_space_asserts (
    // Clock and reset
    input wire       clock,
    input wire       rst,
    // Core access
    input wire [3:0] op,
    input wire [7:0] ioAddr,
    input wire [7:0] dataAddr,
    input wire [2:0] bitNum,
    input wire [7:0] writeData,
    input wire [7:0] readData,
    input wire       skipTaken,
    input wire       extSelect,
    // Register contents
    input wire [7:0] portBDir,
    input wire [7:0] portBOut,
    input wire [7:0] portDDir,
    input wire [7:0] timer0Count
);
    // One clock domain, so one default clocking and disable
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Decode helpers
    wire isMem  = (op == `OP_MEM_FETCH) || (op == `OP_MEM_WRITE);
    wire isBit  = (op == `OP_BIT_SET) || (op == `OP_BIT_CLEAR);
    wire rsvdIo = (ioAddr <= 8'h02) || (ioAddr >= 8'h0c && ioAddr <= 8'h14);

    a_ext_data_only: assert property (extSelect == (isMem && dataAddr >= 8'h60))
        else $error("extSelect disagrees with data access decode");
    a_skip_low_range: assert property (skipTaken |->
        $past(op) inside {`OP_SKIP_HIGH, `OP_SKIP_LOW} && $past(ioAddr) <= 8'h1f)
        else $error("skip taken without a low-range skip access");
    a_idle_read_zero: assert property ((op == `OP_NONE || op == `OP_IO_WRITE
        || op == `OP_MEM_WRITE) |=> readData == 8'h00)
        else $error("read data not zero without a read");
    a_rsvd_read_zero: assert property ((op == `OP_IO_READ && rsvdIo) |=> readData == 8'h00)
        else $error("reserved location read not zero");
    a_out_to_latch: assert property ((op == `OP_IO_WRITE && ioAddr == 8'h05)
        |=> portBOut == $past(writeData))
        else $error("I/O write did not reach port B latch");
    a_mirror_write: assert property ((op == `OP_MEM_WRITE && dataAddr == 8'h25)
        |=> portBOut == $past(writeData))
        else $error("data space write did not reach port B latch");
    a_bit_set_one: assert property ((op == `OP_BIT_SET && ioAddr == 8'h04)
        |=> portBDir == ($past(portBDir) | (8'h01 << $past(bitNum))))
        else $error("bit set changed more than one bit");
    a_bit_clr_one: assert property ((op == `OP_BIT_CLEAR && ioAddr == 8'h0a)
        |=> portDDir == ($past(portDDir) & ~(8'h01 << $past(bitNum))))
        else $error("bit clear changed more than one bit");
    a_bit_high_ignored: assert property ((isBit && ioAddr == 8'h26) |=> $stable(timer0Count))
        else $error("bit op above low range changed a register");
endmodule // io_space_asserts

bind io_register_space_decode io_space_asserts io_space_asserts_inst (
    .clock(clock), .rst(rst), .op(op), .ioAddr(ioAddr), .dataAddr(dataAddr),
    .bitNum(bitNum), .writeData(writeData), .readData(readData), .skipTaken(skipTaken),
    .extSelect(extSelect), .portBDir(portBDir), .portBOut(portBOut), .portDDir(portDDir),
    .timer0Count(timer0Count));

// File: testbench/core_access_model.sv
// Behavioural core issuing I/O, bit and load/store accesses
`timescale 1ns/100ps
`include "io_space_map.vh"
module core_access_model (
    // Clock
    input  wire        clock,
    // Access towards the register space
    output logic [3:0] op,
    output logic [7:0] ioAddr,
    output logic [7:0] dataAddr,
    output logic [2:0] bitNum,
    output logic [7:0] writeData,
    // Answers
    input  wire  [7:0] readData,
    input  wire        skipTaken,
    input  wire        extSelect
);
    // Quiet bus at time zero
    initial begin
        op = `OP_NONE;
        ioAddr = 8'h00;
        dataAddr = 8'h00;
        bitNum = 3'h0;
        writeData = 8'h00;
    end
    // Driven after a falling edge, taken at the rising edge, answer seen at the next fall.
    // Callers only write documented places and zero reserved bits.
    task automatic access(input logic [3:0] o, input logic [7:0] a, input logic [2:0] b,
                          input logic [7:0] d, output logic [7:0] rd, output logic sk,
                          output logic ex);
        @(negedge clock);
        op <= o;
        ioAddr <= a;
        dataAddr <= a;
        bitNum <= b;
        writeData <= d;
        @(posedge clock);
        ex = extSelect;
        @(negedge clock);
        rd = readData;
        sk = skipTaken;
        // Released lines show garbage, not the old value
        op <= `OP_NONE;
        ioAddr <= ~a;
        dataAddr <= ~a;
        writeData <= ~d;
    endtask
endmodule // core_access_model

// File: testbench/io_register_space_decode_tb_top.sv
// Self-checking bench for the lower I/O register space
`timescale 1ns/100ps
`include "io_space_map.vh"
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nFail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module io_register_space_decode_tb_top;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] op;
    logic [7:0] ioAddr, dataAddr, writeData, readData, portBDir, portBOut, portDDir, t0Count;
    logic [2:0] bitNum;
    logic       skipTaken, extSelect, cmpOutput = 1'b0;
    logic [7:0] portBPins = 8'h3c, portDPins = 8'h00, t0Set = 8'h00, t1Set = 8'h00;
    logic [6:0] portCPins = 7'h55;
    logic [7:0] extSet = 8'h00, rv, a, d;
    logic [6:0] portCDir, portCOut;
    logic [7:0] portDOut, extMask, serData, nvCtrl;
    logic       sk, ex;
    logic [7:0] rw [12] = '{8'h04, 8'h05, 8'h0a, 8'h0b, 8'h1e, 8'h20, 8'h21, 8'h26, 8'h27,
                            8'h28, 8'h2a, 8'h2b};
    int         nFail = 0, cmpCount = 0;

    // 25 MHz core clock
    initial forever #20 clock = ~clock;

    io_register_space_decode io_register_space_decode_inst (
        .clock(clock), .rst(rst), .op(op), .ioAddr(ioAddr), .dataAddr(dataAddr),
        .bitNum(bitNum), .writeData(writeData), .readData(readData), .skipTaken(skipTaken),
        .extSelect(extSelect), .portBPins(portBPins), .portCPins(portCPins),
        .portDPins(portDPins), .portBDir(portBDir), .portBOut(portBOut), .portCDir(portCDir),
        .portCOut(portCOut), .portDDir(portDDir), .portDOut(portDOut), .tmr0FlagSet(t0Set),
        .tmr1FlagSet(t1Set), .tmr2FlagSet(8'h00), .pchgFlagSet(8'h00), .extFlagSet(extSet),
        .serFlagSet(8'h00), .cmpFlagSet(8'h00), .resetCauseSet(8'h00), .cmpOutput(cmpOutput),
        .extIrqMask(extMask), .timer0Count(t0Count), .serialData(serData), .nvControl(nvCtrl));

    core_access_model core_access_model_inst (
        .clock(clock), .op(op), .ioAddr(ioAddr), .dataAddr(dataAddr), .bitNum(bitNum),
        .writeData(writeData), .readData(readData), .skipTaken(skipTaken),
        .extSelect(extSelect));

    // One access through the core model
    task automatic go(input logic [3:0] o, input logic [7:0] ad, input logic [2:0] b,
                      input logic [7:0] dt);
        core_access_model_inst.access(o, ad, b, dt, rv, sk, ex);
    endtask

    // Verdict and end of run
    task automatic endSim();
        if (nFail == 0 && cmpCount > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        nFail++;
        endSim();
    end

    initial begin
        repeat (2) @(negedge clock);
        rst = 1'b0;
        // Zero after reset, then write and read through both windows
        for (int i = 0; i < 12; i++) begin
            a = rw[i];
            d = a ^ 8'hc3;
            go(`OP_IO_READ, a, 3'h0, 8'h00); `CHK("reset value", 8'h00, rv)
            if (i % 2) go(`OP_MEM_WRITE, a + 8'h20, 3'h0, d);
            else go(`OP_IO_WRITE, a, 3'h0, d);
            go(`OP_IO_READ, a, 3'h0, 8'h00); `CHK("io read", d, rv)
            go(`OP_MEM_FETCH, a + 8'h20, 3'h0, 8'h00); `CHK("mirror read", d, rv)
        end
        `CHK("portBOut", 8'hc6, portBOut)
        `CHK("portDOut", 8'hc8, portDOut)
        go(`OP_IO_WRITE, 8'h05, 3'h0, 8'ha5); `CHK("io latch", 8'ha5, portBOut)
        go(`OP_MEM_WRITE, 8'h3d, 3'h0, 8'h03); `CHK("ext mask", 8'h03, extMask)
        go(`OP_IO_WRITE, 8'h2e, 3'h0, 8'h5a); `CHK("serial data", 8'h5a, serData)
        go(`OP_IO_WRITE, 8'h07, 3'h0, 8'h7f); `CHK("port C dir", 7'h7f, portCDir)
        // Extended space only from data accesses; I/O addresses above 0x3F neither alias nor read
        go(`OP_MEM_WRITE, 8'h60, 3'h0, 8'h00); `CHK("ext select", 1'b1, ex)
        go(`OP_IO_WRITE, 8'h60, 3'h0, 8'h00); `CHK("io ext select", 1'b0, ex)
        go(`OP_IO_READ, 8'h20, 3'h0, 8'h00); `CHK("no alias write", 8'he3, rv)
        go(`OP_IO_READ, 8'h65, 3'h0, 8'h00); `CHK("io above window", 8'h00, rv)
        // Single-bit set/clear and skip tests in the low range, then set and skip at 0x26 above it
        go(`OP_BIT_SET, 8'h04, 3'h3, 8'h00); `CHK("bit set", 8'hcf, portBDir)
        go(`OP_BIT_CLEAR, 8'h04, 3'h7, 8'h00); `CHK("bit clear", 8'h4f, portBDir)
        go(`OP_BIT_CLEAR, 8'h0a, 3'h0, 8'h00); `CHK("D bit clear", 8'hc8, portDDir)
        go(`OP_BIT_SET, 8'h08, 3'h6, 8'h00); `CHK("C bit set", 7'h40, portCOut)
        go(`OP_BIT_SET, 8'h1f, 3'h2, 8'h00); `CHK("nv bit set", 8'h04, nvCtrl)
        for (int j = 0; j < 4; j++) begin
            go(j % 2 ? `OP_SKIP_LOW : `OP_SKIP_HIGH, 8'h04, j / 2 ? 3'h4 : 3'h3, 8'h00);
            `CHK("skip", j == 0 || j == 3, sk)
        end
        go(`OP_BIT_SET, 8'h26, 3'h1, 8'h00); `CHK("high bit set", 8'he5, t0Count)
        go(`OP_SKIP_HIGH, 8'h26, 3'h0, 8'h00); `CHK("high skip", 1'b0, sk)
        // Status flags clear on a written one only
        @(negedge clock);
        t0Set = 8'hff;
        t1Set = 8'hff;
        extSet = 8'hff;
        @(negedge clock);
        t0Set = 8'h00;
        t1Set = 8'h00;
        extSet = 8'h00;
        go(`OP_IO_READ, 8'h16, 3'h0, 8'h00); `CHK("flags 1", 8'h27, rv)
        go(`OP_IO_WRITE, 8'h15, 3'h0, 8'h00);
        go(`OP_IO_READ, 8'h15, 3'h0, 8'h00); `CHK("zero kept", 8'h07, rv)
        go(`OP_IO_WRITE, 8'h15, 3'h0, 8'h02);
        go(`OP_IO_READ, 8'h15, 3'h0, 8'h00); `CHK("one clears", 8'h05, rv)
        go(`OP_BIT_SET, 8'h15, 3'h0, 8'h00);
        go(`OP_IO_READ, 8'h15, 3'h0, 8'h00); `CHK("bit set flag", 8'h04, rv)
        go(`OP_BIT_CLEAR, 8'h1c, 3'h0, 8'h00);
        go(`OP_IO_READ, 8'h1c, 3'h0, 8'h00); `CHK("bit clr flag", 8'h03, rv)
        // Pins, comparator bit and reserved locations
        cmpOutput = 1'b1;
        go(`OP_IO_READ, 8'h03, 3'h0, 8'h00); `CHK("port B pins", 8'h3c, rv)
        go(`OP_MEM_FETCH, 8'h26, 3'h0, 8'h00); `CHK("port C pins", 8'h55, rv)
        go(`OP_IO_READ, 8'h30, 3'h0, 8'h00); `CHK("comparator", 8'h20, rv)
        for (int k = 0; k < 12; k++) begin
            go(`OP_IO_READ, k < 3 ? k : k + 9, 3'h0, 8'h00); `CHK("reserved", 8'h00, rv)
        end
        // Reset again mid-run: latches and pending flags return to zero
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        `CHK("reset latch", 8'h00, portBOut)
        go(`OP_IO_READ, 8'h15, 3'h0, 8'h00); `CHK("reset flags", 8'h00, rv)
        endSim();
    end
endmodule // io_register_space_decode_tb_top
